/* File: core/embedded_sync_ram_regs.svh */
`ifndef EMBEDDED_SYNC_RAM_REGS_SVH
`define EMBEDDED_SYNC_RAM_REGS_SVH

// ----------------------------------------------------------------
// capacity and width limits per size class
// ----------------------------------------------------------------
`define RAM_SMALL_BITS 576
`define RAM_MEDIUM_BITS 4608
`define RAM_LARGE_BITS 589824
`define RAM_SMALL_MAX_BYTES 2
`define RAM_MEDIUM_MAX_BYTES 4
`define RAM_LARGE_MAX_BYTES 16
`define RAM_BYTE_BITS 9
`define RAM_PARITY_POS 8

`endif

/* File: core/embedded_sync_ram_pkg.sv */
// ----------------------------------------------------------------
// shared types
// ----------------------------------------------------------------
`default_nettype none
package embedded_sync_ram_pkg;
	// port arrangement of one block
	typedef enum logic [1:0] {
		MODE_SINGLE,
		MODE_SIMPLE_DUAL,
		MODE_TRUE_DUAL,
		MODE_DUAL_SINGLE
	} ram_mode_t;
	// physical size class
	typedef enum logic [1:0] {
		CLASS_SMALL,
		CLASS_MEDIUM,
		CLASS_LARGE
	} size_class_t;
endpackage
`default_nettype wire

/* File: core/embedded_sync_ram_block.sv */
`timescale 1ns/1ps
`default_nettype none
`include "embedded_sync_ram_regs.svh"
module embedded_sync_ram_block #(
	parameter embedded_sync_ram_pkg::size_class_t SIZE_CLASS =
		embedded_sync_ram_pkg::CLASS_MEDIUM,
	parameter int BYTES = `RAM_MEDIUM_MAX_BYTES,
	localparam int TOTAL_BITS =
		(SIZE_CLASS == embedded_sync_ram_pkg::CLASS_SMALL) ?
		`RAM_SMALL_BITS :
		(SIZE_CLASS == embedded_sync_ram_pkg::CLASS_MEDIUM) ?
		`RAM_MEDIUM_BITS : `RAM_LARGE_BITS,
	localparam int MAX_BYTES =
		(SIZE_CLASS == embedded_sync_ram_pkg::CLASS_SMALL) ?
		`RAM_SMALL_MAX_BYTES :
		(SIZE_CLASS == embedded_sync_ram_pkg::CLASS_MEDIUM) ?
		`RAM_MEDIUM_MAX_BYTES : `RAM_LARGE_MAX_BYTES,
	localparam int NB = (BYTES > MAX_BYTES) ? MAX_BYTES :
		((BYTES < 1) ? 1 : BYTES),
	localparam int W = NB * `RAM_BYTE_BITS,
	localparam int DEPTH = TOTAL_BITS / W,
	localparam int AW = $clog2(DEPTH)
) (
	input wire logic clock_in,
	input wire logic sys_rst_in,
	input wire embedded_sync_ram_pkg::ram_mode_t mode_in,
	input wire logic flow_through_in,
	input wire logic in_clr_in,
	input wire logic out_clr_in,
	input wire logic a_out_reg_use_in,
	input wire logic [AW-1:0] a_addr_in,
	input wire logic [W-1:0] a_wdata_in,
	input wire logic [NB-1:0] a_be_in,
	input wire logic a_we_in,
	input wire logic a_re_in,
	output logic [W-1:0] a_rdata_out,
	input wire logic b_out_reg_use_in,
	input wire logic [AW-1:0] b_addr_in,
	input wire logic [W-1:0] b_wdata_in,
	input wire logic [NB-1:0] b_be_in,
	input wire logic b_we_in,
	input wire logic b_re_in,
	output logic [W-1:0] b_rdata_out
);
	import embedded_sync_ram_pkg::*;

	// ----------------------------------------------------------------
	// storage and input registers
	// ----------------------------------------------------------------
	// array word: NB bytes of 8 data bits plus a ninth user bit each
	logic [W-1:0] mem [DEPTH];
	logic [AW-1:0] a_addr_q;
	logic [W-1:0] a_wdata_q;
	logic [NB-1:0] a_be_q;
	logic a_we_q;
	logic a_re_q;
	logic [AW-1:0] b_addr_q;
	logic [W-1:0] b_wdata_q;
	logic [NB-1:0] b_be_q;
	logic b_we_q;
	logic b_re_q;
	logic [AW-1:0] b_addr_n;
	logic [W-1:0] a_arr;
	logic [W-1:0] b_arr;
	logic [W-1:0] a_out_q;
	logic [W-1:0] b_out_q;
	ram_mode_t eff_mode;
	logic a_wstrobe;
	logic b_wstrobe;
	logic a_rd_en;
	logic b_rd_en;
	logic flow_act;
	logic [AW-1:0] a_ea;
	logic [AW-1:0] b_ea;
	logic [W-1:0] a_mask;
	logic [W-1:0] b_mask;

	// port inputs registered; input clear empties them asynchronously
	always_ff @(posedge clock_in or posedge sys_rst_in or posedge in_clr_in) begin
		if (sys_rst_in || in_clr_in) begin
			a_addr_q <= '0;
			a_wdata_q <= '0;
			a_be_q <= '0;
			a_we_q <= 1'b0;
			a_re_q <= 1'b0;
			b_addr_q <= '0;
			b_wdata_q <= '0;
			b_be_q <= '0;
			b_we_q <= 1'b0;
			b_re_q <= 1'b0;
		end else begin
			a_addr_q <= a_addr_in;
			a_wdata_q <= a_wdata_in;
			a_be_q <= a_be_in;
			a_we_q <= a_we_in;
			a_re_q <= a_re_in;
			b_addr_q <= b_addr_in;
			b_wdata_q <= b_wdata_in;
			b_be_q <= b_be_in;
			b_we_q <= b_we_in;
			b_re_q <= b_re_in;
		end
	end

	// flow-through read address taken on the falling edge
	always_ff @(negedge clock_in or posedge sys_rst_in or posedge in_clr_in) begin
		if (sys_rst_in || in_clr_in) begin
			b_addr_n <= '0;
		end else if (b_re_in) begin
			b_addr_n <= b_addr_in;
		end
	end

	// ----------------------------------------------------------------
	// mode resolution
	// ----------------------------------------------------------------
	// modes a class cannot host fall back to the nearest legal one
	always_comb begin
		eff_mode = mode_in;
		unique case (mode_in)
			MODE_TRUE_DUAL: begin
				if (SIZE_CLASS == CLASS_SMALL) begin
					eff_mode = MODE_SIMPLE_DUAL;
				end
			end
			MODE_DUAL_SINGLE: begin
				if (SIZE_CLASS == CLASS_SMALL) begin
					eff_mode = MODE_SIMPLE_DUAL;
				end else if (SIZE_CLASS == CLASS_LARGE) begin
					eff_mode = MODE_SINGLE;
				end
			end
			MODE_SINGLE, MODE_SIMPLE_DUAL: begin
				eff_mode = mode_in;
			end
		endcase
	end

	// internal write strobes and read enables from registered requests
	// port a may write in every mode
	assign a_wstrobe = a_we_q;
	assign b_wstrobe = b_we_q && (eff_mode == MODE_TRUE_DUAL ||
		eff_mode == MODE_DUAL_SINGLE);
	assign a_rd_en = a_re_q && (eff_mode != MODE_SIMPLE_DUAL);
	assign b_rd_en = b_re_q && (eff_mode != MODE_SINGLE);
	assign flow_act = flow_through_in && (eff_mode == MODE_SIMPLE_DUAL) &&
		(SIZE_CLASS != CLASS_LARGE);

	// two single-port memories each confined to one half
	always_comb begin
		a_ea = a_addr_q;
		b_ea = b_addr_q;
		if (eff_mode == MODE_DUAL_SINGLE) begin
			a_ea = {1'b0, a_addr_q[AW-2:0]};
			b_ea = {1'b1, b_addr_q[AW-2:0]};
		end
	end

	// byte enables widen to nine-bit lanes; small block writes whole words
	always_comb begin
		a_mask = '0;
		b_mask = '0;
		for (int i = 0; i < NB; i++) begin
			if (SIZE_CLASS == CLASS_SMALL || a_be_q[i]) begin
				a_mask[i*`RAM_BYTE_BITS +: `RAM_BYTE_BITS] = '1;
			end
			if (SIZE_CLASS == CLASS_SMALL || b_be_q[i]) begin
				b_mask[i*`RAM_BYTE_BITS +: `RAM_BYTE_BITS] = '1;
			end
		end
	end

	// ----------------------------------------------------------------
	// array write and read
	// ----------------------------------------------------------------
	// port a written last so it wins a same-address collision
	always_ff @(posedge clock_in) begin
		if (b_wstrobe) begin
			mem[b_ea] <= (mem[b_ea] & ~b_mask) | (b_wdata_q & b_mask);
		end
		if (a_wstrobe) begin
			mem[a_ea] <= (mem[a_ea] & ~a_mask) | (a_wdata_q & a_mask);
		end
	end

	// array read stage, old data on read during write
	always_ff @(posedge clock_in or posedge sys_rst_in) begin
		if (sys_rst_in) begin
			a_arr <= '0;
			b_arr <= '0;
		end else begin
			if (a_rd_en) begin
				a_arr <= mem[a_ea];
			end
			if (b_rd_en) begin
				b_arr <= mem[b_ea];
			end
		end
	end

	// output registers, cleared at once by the output clear
	always_ff @(posedge clock_in or posedge sys_rst_in or posedge out_clr_in) begin
		if (sys_rst_in || out_clr_in) begin
			a_out_q <= '0;
			b_out_q <= '0;
		end else begin
			a_out_q <= a_arr;
			b_out_q <= b_arr;
		end
	end

	// output select: registered, bypassed, or flow-through
	assign a_rdata_out = a_out_reg_use_in ? a_out_q : a_arr;
	assign b_rdata_out = flow_act ? mem[b_addr_n] :
		(b_out_reg_use_in ? b_out_q : b_arr);

	// ----------------------------------------------------------------
	// assertions
	// ----------------------------------------------------------------
	sequence s_a_read;
		a_rd_en && !out_clr_in;
	endsequence

	sequence s_a_write_alone;
		a_wstrobe && !(b_wstrobe && b_ea == a_ea);
	endsequence

	property p_small_no_b_write;
		@(posedge clock_in) disable iff (sys_rst_in)
		(SIZE_CLASS == CLASS_SMALL) |-> !b_wstrobe;
	endproperty
	a_small_no_b_write: assert property (p_small_no_b_write)
		else $error("small block wrote through port b");

	property p_write_store;
		@(posedge clock_in) disable iff (sys_rst_in)
		s_a_write_alone |=>
		((mem[$past(a_ea)] & $past(a_mask)) ==
		($past(a_wdata_q) & $past(a_mask)));
	endproperty
	a_write_store: assert property (p_write_store)
		else $error("enabled bytes not written");

	property p_masked_keep;
		@(posedge clock_in) disable iff (sys_rst_in)
		s_a_write_alone |=>
		((mem[$past(a_ea)] & ~$past(a_mask)) ==
		($past(mem[a_ea]) & ~$past(a_mask)));
	endproperty
	a_masked_keep: assert property (p_masked_keep)
		else $error("masked byte changed on write");

	property p_input_capture;
		@(posedge clock_in) disable iff (sys_rst_in || in_clr_in)
		1'b1 |=> (a_addr_q == $past(a_addr_in)) && (a_we_q == $past(a_we_in));
	endproperty
	a_input_capture: assert property (p_input_capture)
		else $error("port a input not registered");

	property p_in_clear;
		@(posedge clock_in) disable iff (sys_rst_in)
		in_clr_in |-> (a_addr_q == '0) && !a_we_q && !b_we_q && !a_re_q;
	endproperty
	a_in_clear: assert property (p_in_clear)
		else $error("input registers not cleared");

	property p_out_clear;
		@(posedge clock_in) disable iff (sys_rst_in)
		(out_clr_in && a_out_reg_use_in) |-> (a_rdata_out == '0);
	endproperty
	a_out_clear: assert property (p_out_clear)
		else $error("output clear not seen at once");

	property p_bypass_latency;
		@(posedge clock_in) disable iff (sys_rst_in)
		s_a_read ##1 !a_out_reg_use_in |-> a_rdata_out == $past(mem[a_ea]);
	endproperty
	a_bypass_latency: assert property (p_bypass_latency)
		else $error("bypassed read not one clock late");

	property p_reg_latency;
		@(posedge clock_in) disable iff (sys_rst_in || out_clr_in)
		s_a_read ##2 a_out_reg_use_in |-> a_rdata_out == $past(mem[a_ea], 2);
	endproperty
	a_reg_latency: assert property (p_reg_latency)
		else $error("registered read not two clocks late");

	property p_flow_through;
		@(posedge clock_in) disable iff (sys_rst_in)
		(flow_act && b_re_in) |-> b_rdata_out == mem[b_addr_in];
	endproperty
	a_flow_through: assert property (p_flow_through)
		else $error("flow-through read mismatch");

	property p_halves;
		@(posedge clock_in) disable iff (sys_rst_in)
		(eff_mode == MODE_DUAL_SINGLE) |-> !a_ea[AW-1] && b_ea[AW-1];
	endproperty
	a_halves: assert property (p_halves)
		else $error("single-port halves overlap");

endmodule
`default_nettype wire

/* File: testbench/fabric_logic_model.sv */
`timescale 1ns/1ps
`default_nettype none
module fabric_logic_model #(
	parameter int AW = 7,
	parameter int W = 36,
	parameter int NB = 4
) (
	output logic [1:0][AW-1:0] addr_out,
	output logic [1:0][W-1:0] wdata_out,
	output logic [1:0][NB-1:0] be_out,
	output logic [1:0] we_out,
	output logic [1:0] re_out
);
	// ------------------------------------------------
	// request staging for ports a (0) and b (1)
	// ------------------------------------------------
	// quiet start, nothing requested
	initial begin
		addr_out = '0;
		wdata_out = '0;
		be_out = '0;
		we_out = '0;
		re_out = '0;
	end
	// a whole request changes together in one step
	task automatic put(input int p, input logic [AW-1:0] ad,
		input logic [W-1:0] d, input logic [NB-1:0] be, input logic we,
		input logic re);
		addr_out[p] = ad;
		wdata_out[p] = d;
		be_out[p] = be;
		we_out[p] = we;
		re_out[p] = re;
	endtask
	// released address and data lines stop showing the last value; byte enables keep it
	task automatic idle(input int p);
		we_out[p] = 1'b0;
		re_out[p] = 1'b0;
		wdata_out[p] = ~wdata_out[p];
		addr_out[p] = ~addr_out[p];
	endtask
endmodule
`default_nettype wire

/* File: testbench/embedded_sync_ram_block_tb.sv */
`timescale 1ns/1ps
`default_nettype none
module embedded_sync_ram_block_tb;
	import embedded_sync_ram_pkg::*;
	// ------------------------------------------------
	// signals and instances
	// ------------------------------------------------
	typedef struct packed {
		logic [6:0] ad;
		logic [3:0] be;
		logic [35:0] exp;
	} row_t;
	localparam row_t ROWS [5] = '{
		'{7'h00, 4'h0, 36'hF_FFFF_FFFF}, '{7'h01, 4'h1, 36'hF_FFFF_FE00},
		'{7'h02, 4'h6, 36'hF_F800_01FF}, '{7'h7F, 4'h8, 36'h0_07FF_FFFF},
		'{7'h40, 4'hF, 36'h0_0000_0000}};
	logic clock_in = 1'b0;
	logic sys_rst_in = 1'b1;
	ram_mode_t mode = MODE_TRUE_DUAL;
	logic flow = 1'b0;
	logic in_clr = 1'b0;
	logic out_clr = 1'b0;
	logic a_use = 1'b0;
	logic b_use = 1'b0;
	logic [1:0][6:0] addr;
	logic [1:0][35:0] wdata;
	logic [1:0][3:0] be;
	logic [1:0] we;
	logic [1:0] re;
	logic [35:0] a_rdata;
	logic [35:0] b_rdata;
	int mismatches = 0;
	int checks_done = 0;
	// 50 MHz clock
	always #10 clock_in = ~clock_in;
	fabric_logic_model fab (.addr_out(addr), .wdata_out(wdata),
		.be_out(be), .we_out(we), .re_out(re));
	embedded_sync_ram_block dut (.clock_in(clock_in),
		.sys_rst_in(sys_rst_in), .mode_in(mode), .flow_through_in(flow),
		.in_clr_in(in_clr), .out_clr_in(out_clr),
		.a_out_reg_use_in(a_use), .a_addr_in(addr[0]),
		.a_wdata_in(wdata[0]), .a_be_in(be[0]), .a_we_in(we[0]),
		.a_re_in(re[0]), .a_rdata_out(a_rdata),
		.b_out_reg_use_in(b_use), .b_addr_in(addr[1]),
		.b_wdata_in(wdata[1]), .b_be_in(be[1]), .b_we_in(we[1]),
		.b_re_in(re[1]), .b_rdata_out(b_rdata));
	// ------------------------------------------------
	// helpers
	// ------------------------------------------------
	task automatic chk(input logic [35:0] got, input logic [35:0] exp);
		checks_done++;
		if (got !== exp) begin
			mismatches++;
			$display("unexpected at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	// one step is one rising edge plus the drive delay
	task automatic step(input int n);
		repeat (n) @(posedge clock_in);
		#1;
	endtask
	task automatic wr(input int p, input logic [6:0] ad,
		input logic [35:0] d, input logic [3:0] m);
		fab.put(p, ad, d, m, 1'b1, 1'b0);
		step(1);
		fab.idle(p);
		step(1);
	endtask
	task automatic rd(input int p, input logic [6:0] ad);
		fab.put(p, ad, '0, '0, 1'b0, 1'b1);
		step(1);
		fab.idle(p);
		step(1);
	endtask
	task automatic final_report;
		$display("checks %0d mismatches %0d", checks_done, mismatches);
		if (mismatches == 0 && checks_done > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask
	// hang guard, far beyond the roughly 75 cycles used
	initial begin
		#(5000 * 20);
		mismatches++;
		final_report();
	end
	// ------------------------------------------------
	// tests
	// ------------------------------------------------
	initial begin
		step(6);
		chk(a_rdata, 36'h0);
		chk(b_rdata, 36'h0);
		sys_rst_in = 1'b0;
		$display("reset test done");
		// masked writes over all-ones words, read on both ports
		foreach (ROWS[i]) begin
			wr(0, ROWS[i].ad, 36'hF_FFFF_FFFF, 4'hF);
			wr(0, ROWS[i].ad, 36'h0, ROWS[i].be);
			rd(0, ROWS[i].ad);
			chk(a_rdata, ROWS[i].exp);
			rd(1, ROWS[i].ad);
			chk(b_rdata, ROWS[i].exp);
		end
		$display("table test done");
		// read killed by input clear, output holds
		rd(0, ROWS[1].ad);
		fab.put(0, ROWS[2].ad, '0, '0, 1'b0, 1'b1);
		step(1);
		in_clr = 1'b1;
		fab.idle(0);
		step(1);
		chk(a_rdata, ROWS[1].exp);
		in_clr = 1'b0;
		$display("input clear test done");
		// registered output: one clock later than bypass
		a_use = 1'b1;
		rd(0, ROWS[1].ad);
		step(1);
		rd(0, ROWS[3].ad);
		chk(a_rdata, ROWS[1].exp);
		step(1);
		chk(a_rdata, ROWS[3].exp);
		out_clr = 1'b1;
		#1;
		chk(a_rdata, 36'h0);
		step(1);
		chk(a_rdata, 36'h0);
		out_clr = 1'b0;
		a_use = 1'b0;
		$display("output register test done");
		// two single-port memories in separate halves
		mode = MODE_DUAL_SINGLE;
		wr(0, 7'h03, 36'h1_2345_6789, 4'hF);
		wr(1, 7'h03, 36'hA_BCDE_F012, 4'hF);
		rd(0, 7'h03);
		chk(a_rdata, 36'h1_2345_6789);
		rd(1, 7'h03);
		chk(b_rdata, 36'hA_BCDE_F012);
		$display("split memory test done");
		// flow-through read on falling edge
		mode = MODE_SIMPLE_DUAL;
		flow = 1'b1;
		wr(0, 7'h09, 36'h5_A5A5_A5A5, 4'hF);
		fab.put(1, 7'h09, '0, '0, 1'b0, 1'b1);
		@(negedge clock_in);
		#1;
		chk(b_rdata, 36'h5_A5A5_A5A5);
		step(1);
		fab.idle(1);
		$display("flow-through test done");
		// single port ignores b writes; b output register adds a clock
		flow = 1'b0;
		mode = MODE_SINGLE;
		wr(1, 7'h09, 36'h0, 4'hF);
		rd(0, 7'h09);
		chk(a_rdata, 36'h5_A5A5_A5A5);
		mode = MODE_TRUE_DUAL;
		b_use = 1'b1;
		rd(1, 7'h09);
		chk(b_rdata, 36'hA_BCDE_F012);
		step(1);
		chk(b_rdata, 36'h5_A5A5_A5A5);
		$display("port b register test done");
		final_report();
	end
endmodule
`default_nettype wire
